// [logic/wdws_map.svh]
// register offsets, field positions, reset values and timing constants of the watchdog
`ifndef WDWS_MAP_SVH
`define WDWS_MAP_SVH
`define WDWS_ADDR_W 4
`define WDWS_DATA_W 8
`define WDWS_CODE_W 4
`define WDWS_CNT_W 15
`define WDWS_ADDR_CTRL 4'h0
`define WDWS_ADDR_CONFIG 4'h1
`define WDWS_ADDR_EARLY_WARNING_OFFSET_CTRL 4'h2
`define WDWS_ADDR_IENCLR 4'h4
`define WDWS_ADDR_IENSET 4'h5
`define WDWS_ADDR_FLAGS 4'h6
`define WDWS_ADDR_STATUS 4'h7
`define WDWS_ADDR_SERVICE 4'h8
`define WDWS_ENABLE_BIT 1
`define WDWS_EW_BIT 0
`define WDWS_BUSY_BIT 7
`define WDWS_SERVICE_KEY 8'hA5
`define WDWS_BYTE_ZERO 8'h00
`define WDWS_CODE_ZERO 4'h0
`define WDWS_CNT_ZERO 15'h0000
`define WDWS_CNT_ONE 15'h0001
`define WDWS_MIN_CYCLES 15'h0008
`define WDWS_MAX_CYCLES 15'h4000
`define WDWS_MAX_CODE 4'hB
`endif

// [logic/wdws_pkg.sv]
// types and the period decode shared by the watchdog files
`include "wdws_map.svh"
package wdws_pkg;
  typedef struct packed {
    logic [`WDWS_ADDR_W-1:0] addr;
    logic [`WDWS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wdws_bus_req_t;

  typedef struct packed {
    logic enable;
    logic [`WDWS_CODE_W-1:0] period_code;
    logic [`WDWS_CODE_W-1:0] warning_code;
  } wdws_nvm_row_t;

  typedef enum logic [1:0] {
    WDWS_OP_NONE = 2'b00,
    WDWS_OP_CTRL = 2'b01,
    WDWS_OP_KEY = 2'b10
  } wdws_op_t;

  // reserved codes fall back to the longest setting so a bad code never shortens a period
  function automatic logic [`WDWS_CNT_W-1:0] wdws_cycles(input logic [`WDWS_CODE_W-1:0] code);
    if (code > `WDWS_MAX_CODE) begin
      wdws_cycles = `WDWS_MAX_CYCLES;
    end else begin
      wdws_cycles = `WDWS_MIN_CYCLES << code;
    end
  endfunction
endpackage

// [logic/wdws_counter.sv]
// watchdog tick counter, cleared on restart or while stopped
`timescale 1ns/1ps
`include "wdws_map.svh"
module wdws_counter import wdws_pkg::*; #(
  parameter int CW = `WDWS_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  // state
  output logic [CW-1:0] count
);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (restart || !run) begin
      count_next = CW'(`WDWS_CNT_ZERO);
    end else if (tick) begin
      count_next = count_reg + CW'(`WDWS_CNT_ONE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= CW'(`WDWS_CNT_ZERO);
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule

// [logic/wdws_top.sv]
// watchdog early warning, interrupt, sync status and service register
// Operation
// - early warning after coded count of ticks
// - warning offset loaded from user row
// - enable-clear write one disables interrupt
// - enable-set write one enables interrupt
// - flag bit 0 set at warning point
// - write one clears flag, zero ignored
// - busy bit 7 during domain transfer
// - key 0xA5 restarts timeout period
// - other service value resets system immediately
// - timeout period from 4-bit coded count
// - protected registers writable only while disabled
// - control writes and service key writes synchronized
// - one write during busy waits and completes after transfer; a later write while it waits replaces it
`timescale 1ns/1ps
`include "wdws_map.svh"
module wdws_top import wdws_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire wdws_bus_req_t bus_req,
  output logic [`WDWS_DATA_W-1:0] rdata,
  // start-up configuration
  input wire wdws_nvm_row_t nvm_row,
  // watchdog count clock, sampled as a pin
  input wire logic watchdog_count_clock,
  // outputs
  output logic irq,
  output logic sys_reset_req
);
  // count clock sampling
  logic [2:0] wclk_sync_reg;
  logic [2:0] wclk_sync_next;
  logic wclk_level_reg;
  logic wclk_level_next;
  logic wclk_prev_reg;
  logic wclk_prev_next;
  logic tick;

  always_comb begin
    wclk_sync_next = {wclk_sync_reg[1:0], watchdog_count_clock};
    wclk_level_next = wclk_level_reg;
    if (wclk_sync_reg[1] == wclk_sync_reg[2]) begin
      wclk_level_next = wclk_sync_reg[2];
    end
    wclk_prev_next = wclk_level_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wclk_sync_reg <= 3'h0;
      wclk_level_reg <= 1'b0;
      wclk_prev_reg <= 1'b0;
    end else begin
      wclk_sync_reg <= wclk_sync_next;
      wclk_level_reg <= wclk_level_next;
      wclk_prev_reg <= wclk_prev_next;
    end
  end

  assign tick = wclk_level_reg && !wclk_prev_reg;

  // register state
  logic load_reg, load_next;
  logic enable_reg, enable_next;
  logic run_reg, run_next;
  logic [`WDWS_CODE_W-1:0] period_code_reg, period_code_next;
  logic [`WDWS_CODE_W-1:0] warning_offset_code_reg, warning_offset_code_next;
  logic irq_en_reg, irq_en_next;
  logic flag_reg, flag_next;
  wdws_op_t op_reg, op_next;
  wdws_op_t queue_reg, queue_next;
  logic sys_reset_reg, sys_reset_next;
  logic [`WDWS_DATA_W-1:0] rdata_reg, rdata_next;

  logic [`WDWS_CNT_W-1:0] count;
  logic [`WDWS_CNT_W-1:0] warn_limit;
  logic [`WDWS_CNT_W-1:0] period_limit;
  logic ew_hit;
  logic timeout;
  logic apply;
  logic key_apply;
  logic sync_busy_flag;
  logic wr_ctrl, wr_config, wr_early_warning_offset_ctrl, wr_ienclr, wr_ienset, wr_flags, wr_service;
  logic rd_flags;
  wdws_op_t new_op;

  assign warn_limit = wdws_cycles(warning_offset_code_reg) - `WDWS_CNT_ONE;
  assign period_limit = wdws_cycles(period_code_reg) - `WDWS_CNT_ONE;
  assign ew_hit = run_reg && tick && (count == warn_limit);
  // a key finishing on the last tick of the period still counts as serviced
  assign timeout = run_reg && tick && (count == period_limit) && !key_apply;
  assign sync_busy_flag = (op_reg != WDWS_OP_NONE);
  // a pending transfer finishes on the next count clock edge
  assign apply = sync_busy_flag && tick;
  assign key_apply = apply && (op_reg == WDWS_OP_KEY);

  assign wr_ctrl = bus_req.wr && (bus_req.addr == `WDWS_ADDR_CTRL);
  assign wr_config = bus_req.wr && (bus_req.addr == `WDWS_ADDR_CONFIG);
  assign wr_early_warning_offset_ctrl = bus_req.wr && (bus_req.addr == `WDWS_ADDR_EARLY_WARNING_OFFSET_CTRL);
  assign wr_ienclr = bus_req.wr && (bus_req.addr == `WDWS_ADDR_IENCLR);
  assign wr_ienset = bus_req.wr && (bus_req.addr == `WDWS_ADDR_IENSET);
  assign wr_flags = bus_req.wr && (bus_req.addr == `WDWS_ADDR_FLAGS);
  assign wr_service = bus_req.wr && (bus_req.addr == `WDWS_ADDR_SERVICE);
  assign rd_flags = bus_req.rd && (bus_req.addr == `WDWS_ADDR_FLAGS);

  wdws_counter #(
    .CW(`WDWS_CNT_W)
  ) wdws_counter_i (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .run(run_reg),
    .restart(key_apply || timeout),
    .count(count)
  );

  always_comb begin
    load_next = 1'b0;
    enable_next = enable_reg;
    run_next = run_reg;
    period_code_next = period_code_reg;
    warning_offset_code_next = warning_offset_code_reg;
    irq_en_next = irq_en_reg;
    flag_next = flag_reg;
    op_next = op_reg;
    queue_next = queue_reg;
    sys_reset_next = 1'b0;
    rdata_next = `WDWS_BYTE_ZERO;
    new_op = WDWS_OP_NONE;
    if (load_reg) begin
      // start-up values come from the user row, not from reset constants
      enable_next = nvm_row.enable;
      run_next = nvm_row.enable;
      period_code_next = nvm_row.period_code;
      warning_offset_code_next = nvm_row.warning_code;
    end else begin
      if (wr_ctrl) begin
        enable_next = bus_req.wdata[`WDWS_ENABLE_BIT];
        new_op = WDWS_OP_CTRL;
      end
      if (wr_config && !enable_reg) begin
        period_code_next = bus_req.wdata[`WDWS_CODE_W-1:0];
      end
      if (wr_early_warning_offset_ctrl && !enable_reg) begin
        warning_offset_code_next = bus_req.wdata[`WDWS_CODE_W-1:0];
      end
      if (wr_service) begin
        if (bus_req.wdata == `WDWS_SERVICE_KEY) begin
          new_op = WDWS_OP_KEY;
        end else begin
          sys_reset_next = 1'b1;
        end
      end
    end
    if (timeout) begin
      sys_reset_next = 1'b1;
    end
    if (wr_ienclr && bus_req.wdata[`WDWS_EW_BIT]) begin
      irq_en_next = 1'b0;
    end
    if (wr_ienset && bus_req.wdata[`WDWS_EW_BIT]) begin
      irq_en_next = 1'b1;
    end
    // the new event wins over a clear in the same cycle
    if ((wr_flags && bus_req.wdata[`WDWS_EW_BIT]) || rd_flags) begin
      flag_next = 1'b0;
    end
    if (ew_hit) begin
      flag_next = 1'b1;
    end
    // one waiting slot stands in for the bus stall; the port can never wait
    if (apply) begin
      if (op_reg == WDWS_OP_CTRL) begin
        run_next = enable_reg;
      end
      if (queue_reg != WDWS_OP_NONE) begin
        op_next = queue_reg;
        queue_next = new_op;
      end else begin
        op_next = new_op;
        queue_next = WDWS_OP_NONE;
      end
    end else if (new_op != WDWS_OP_NONE) begin
      if (sync_busy_flag) begin
        queue_next = new_op;
      end else begin
        op_next = new_op;
      end
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `WDWS_ADDR_CTRL: rdata_next[`WDWS_ENABLE_BIT] = enable_reg;
        `WDWS_ADDR_CONFIG: rdata_next[`WDWS_CODE_W-1:0] = period_code_reg;
        `WDWS_ADDR_EARLY_WARNING_OFFSET_CTRL: rdata_next[`WDWS_CODE_W-1:0] = warning_offset_code_reg;
        `WDWS_ADDR_IENCLR: rdata_next[`WDWS_EW_BIT] = irq_en_reg;
        `WDWS_ADDR_IENSET: rdata_next[`WDWS_EW_BIT] = irq_en_reg;
        `WDWS_ADDR_FLAGS: rdata_next[`WDWS_EW_BIT] = flag_reg;
        `WDWS_ADDR_STATUS: rdata_next[`WDWS_BUSY_BIT] = sync_busy_flag;
        default: rdata_next = `WDWS_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      load_reg <= 1'b1;
      enable_reg <= 1'b0;
      run_reg <= 1'b0;
      period_code_reg <= `WDWS_CODE_ZERO;
      warning_offset_code_reg <= `WDWS_CODE_ZERO;
      irq_en_reg <= 1'b0;
      flag_reg <= 1'b0;
      op_reg <= WDWS_OP_NONE;
      queue_reg <= WDWS_OP_NONE;
      sys_reset_reg <= 1'b0;
      rdata_reg <= `WDWS_BYTE_ZERO;
    end else begin
      load_reg <= load_next;
      enable_reg <= enable_next;
      run_reg <= run_next;
      period_code_reg <= period_code_next;
      warning_offset_code_reg <= warning_offset_code_next;
      irq_en_reg <= irq_en_next;
      flag_reg <= flag_next;
      op_reg <= op_next;
      queue_reg <= queue_next;
      sys_reset_reg <= sys_reset_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign sys_reset_req = sys_reset_reg;
  assign irq = flag_reg && irq_en_reg;

  AST_EW_SETS_FLAG: assert property (@(posedge clk) disable iff (rst)
    ew_hit |=> flag_reg && (irq == irq_en_reg))
    else $error("early warning did not set the flag");

  AST_EW_POINT: assert property (@(posedge clk) disable iff (rst)
    $rose(flag_reg) |-> $past(tick) && ($past(count) == $past(warn_limit)))
    else $error("flag rose away from the warning point");

  AST_IEN_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (wr_ienclr && bus_req.wdata[`WDWS_EW_BIT]) |=> !irq_en_reg && !irq)
    else $error("enable clear did not disable the interrupt");

  AST_IEN_SET: assert property (@(posedge clk) disable iff (rst)
    (wr_ienset && bus_req.wdata[`WDWS_EW_BIT]) |=> irq_en_reg)
    else $error("enable set did not enable the interrupt");

  AST_FLAG_W1C: assert property (@(posedge clk) disable iff (rst)
    (wr_flags && bus_req.wdata[`WDWS_EW_BIT] && !ew_hit) |=> !flag_reg)
    else $error("write one did not clear the flag");

  AST_BUSY_SET: assert property (@(posedge clk) disable iff (rst)
    (!load_reg && (wr_ctrl || (wr_service && bus_req.wdata == `WDWS_SERVICE_KEY)))
    |=> sync_busy_flag)
    else $error("busy not set by a synchronized write");

  AST_BUSY_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (apply && queue_reg == WDWS_OP_NONE && !wr_ctrl && !wr_service) |=> !sync_busy_flag)
    else $error("busy not cleared after the transfer");

  AST_QUEUED_RUNS: assert property (@(posedge clk) disable iff (rst)
    (apply && queue_reg != WDWS_OP_NONE) |=> sync_busy_flag && (op_reg == $past(queue_reg)))
    else $error("queued operation lost");

  AST_KEY_RESTART: assert property (@(posedge clk) disable iff (rst)
    key_apply |=> (count == `WDWS_CNT_ZERO)
    && (sys_reset_req == $past(wr_service && (bus_req.wdata != `WDWS_SERVICE_KEY))))
    else $error("key did not restart the period");

  AST_BAD_KEY: assert property (@(posedge clk) disable iff (rst)
    (wr_service && !load_reg && bus_req.wdata != `WDWS_SERVICE_KEY) |=> sys_reset_req)
    else $error("wrong key did not reset the system");

  AST_TIMEOUT: assert property (@(posedge clk) disable iff (rst)
    timeout |=> sys_reset_req ##1 (count <= `WDWS_CNT_ONE))
    else $error("timeout did not reset the system");

  AST_PROTECT: assert property (@(posedge clk) disable iff (rst)
    (wr_early_warning_offset_ctrl && enable_reg && !load_reg) |=> $stable(warning_offset_code_reg))
    else $error("protected register changed while enabled");

  AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
    (ew_hit && irq_en_reg && !wr_ienclr) |=> irq)
    else $error("interrupt not raised on an enabled warning");

  AST_LOAD_OFFSET: assert property (@(posedge clk) disable iff (rst)
    load_reg |=> warning_offset_code_reg == $past(nvm_row.warning_code))
    else $error("warning offset not loaded from the user row");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
    (bus_req.rd && (bus_req.addr == `WDWS_ADDR_STATUS))
    |=> rdata[`WDWS_BUSY_BIT] == $past(sync_busy_flag))
    else $error("status read does not show the busy state");

  AST_CTRL_APPLY: assert property (@(posedge clk) disable iff (rst)
    (apply && (op_reg == WDWS_OP_CTRL)) |=> run_reg == $past(enable_reg))
    else $error("control transfer did not reach the counter");
endmodule

// [verification/wdws_top_tb.sv]
// self-checking testbench of the watchdog warning and service block
`timescale 1ns/1ps
module wdws_top_tb import wdws_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wdws_bus_req_t bus_req = '0;
  wdws_nvm_row_t nvm_row = '{enable: 1'b0, period_code: 4'h1, warning_code: 4'h3};
  logic watchdog_count_clock = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic sys_reset_req;
  int n_errors = 0;
  int checked = 0;
  int n_resets = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  wdws_top wdws_top_i (
    .clk(clk),
    .rst(rst),
    .bus_req(bus_req),
    .rdata(rdata),
    .nvm_row(nvm_row),
    .watchdog_count_clock(watchdog_count_clock),
    .irq(irq),
    .sys_reset_req(sys_reset_req)
  );

  // reset pulses are counted here so long tick runs cannot miss one
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sys_reset_req === 1'b1) begin
      n_resets <= n_resets + 1;
    end
    if (cycles == 6000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the taking edge
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // one count-clock period is 12 bus cycles, well above the filter delay
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (6) @(posedge clk);
      watchdog_count_clock <= 1'b1;
      repeat (6) @(posedge clk);
      watchdog_count_clock <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic t_reset_values();
    rd_chk(4'h4, 8'h00);
    rd_chk(4'h5, 8'h00);
    rd_chk(4'h6, 8'h00);
    rd_chk(4'h7, 8'h00);
    rd_chk(4'h8, 8'h00);
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h2, 8'h03);
  endtask

  task automatic t_enables();
    wr(4'h5, 8'h00);
    rd_chk(4'h4, 8'h00);
    wr(4'h5, 8'h01);
    rd_chk(4'h4, 8'h01);
    rd_chk(4'h5, 8'h01);
    wr(4'h4, 8'h00);
    rd_chk(4'h5, 8'h01);
    wr(4'h4, 8'h01);
    rd_chk(4'h5, 8'h00);
    wr(4'h5, 8'h01);
  endtask

  task automatic t_config_and_enable();
    wr(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00);
    wr(4'h1, 8'h01);
    rd_chk(4'h1, 8'h01);
    wr(4'h0, 8'h02);
    rd_chk(4'h7, 8'h80);
    ticks(1);
    rd_chk(4'h7, 8'h00);
    wr(4'h2, 8'h05);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h0, 8'h02);
  endtask

  // offset code 0 gives the warning on the 8th counted tick
  task automatic t_warning();
    ticks(6);
    chk({7'h00, irq}, 8'h00);
    ticks(2);
    chk({7'h00, irq}, 8'h01);
    wr(4'h4, 8'h01);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr(4'h5, 8'h01);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(4'h6, 8'h00);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(4'h6, 8'h01);
    #1;
    chk({7'h00, irq}, 8'h00);
  endtask

  // period code 1 is 16 ticks; the restart on tick 1 pushes the timeout to tick 17
  task automatic t_service();
    int base;
    base = n_resets;
    wr(4'h8, 8'hA5);
    rd_chk(4'h7, 8'h80);
    ticks(14);
    chk(8'(n_resets - base), 8'h00);
    chk({7'h00, irq}, 8'h01);
    rd_chk(4'h6, 8'h01);
    rd_chk(4'h6, 8'h00);
    ticks(4);
    chk(8'(n_resets - base), 8'h01);
  endtask

  // a second synchronized write while busy waits for the first to finish
  task automatic t_queue();
    int base;
    base = n_resets;
    wr(4'h8, 8'hA5);
    wr(4'h0, 8'h02);
    rd_chk(4'h7, 8'h80);
    ticks(1);
    rd_chk(4'h7, 8'h80);
    ticks(1);
    rd_chk(4'h7, 8'h00);
    rd_chk(4'h0, 8'h02);
    chk(8'(n_resets - base), 8'h00);
  endtask

  task automatic t_bad_key();
    wr(4'h8, 8'h5A);
    #1;
    chk({7'h00, sys_reset_req}, 8'h01);
    rd_chk(4'h7, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_enables();
    t_config_and_enable();
    t_warning();
    t_service();
    t_queue();
    t_bad_key();
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
